// >>> fault_history_and_hour_monitor.sv
`timescale 1ns/1ps
// What this block does
// R1 - four fault slots, newest in first, older entries shift down each fault
// R2 - hours from previous to latest fault, up to 65536, cleared on reset
// R3 - on fault capture frequencies, current, voltages and terminal states
// R4 - snapshot values clear once faults cleared and system reset
// R5 - power-on hours count 0 to 65535 then wrap to 0
// R6 - run hours count while running, 0 to 65535, then wrap
// R7 - live input terminals shown as eight bits, 1 closed, 0 open
// R8 - terminal snapshots use the same encoding as live status
// R9 - selector codes 05, 06, 07 route voltage, current, third input
// R10 - encoder speed feedback in 0.1 percent steps, 1000 is max frequency
// R11 - motor speed in rpm, valid only with encoder feedback enabled
// R12 - voltage input reported as percentage of 0 to 10 V span
// R13 - with closed loop controller on, third input is its target
// R14 - all hour counters advance from one common hour tick
module fault_history_and_hour_monitor #(
  parameter longint HOUR_CYCLES_P = fault_monitor_pkg::HOUR_CYCLES
) (
  // clock and reset
  input  wire logic                                  MCLK_I,
  input  wire logic                                  RESET_I,
  // fault events
  input  wire logic                                  FAULT_PULSE_I,
  input  wire logic [fault_monitor_pkg::CODE_W-1:0]  FAULT_CODE_I,
  input  wire logic                                  FAULT_RESET_I,
  // drive state
  input  wire logic                                  RUN_I,
  input  wire fault_monitor_pkg::drive_snap_t        LIVE_I,
  input  wire fault_monitor_pkg::analog_in_t         ANALOG_IN_I,
  input  wire logic [fault_monitor_pkg::VALUE_W-1:0] ENCODER_SPEED_I,
  input  wire logic [fault_monitor_pkg::VALUE_W-1:0] MOTOR_RPM_I,
  input  wire logic                                  ENCODER_FEEDBACK_EN_I,
  input  wire logic                                  CLOSED_LOOP_EN_I,
  // selectors
  input  wire logic [fault_monitor_pkg::SEL_W-1:0]   FIRST_OUTPUT_SELECTOR_I,
  input  wire logic [fault_monitor_pkg::SEL_W-1:0]   SECOND_OUTPUT_SELECTOR_I,
  // fault history
  output logic [fault_monitor_pkg::CODE_W-1:0]       NEWEST_FAULT_SLOT_O,
  output logic [fault_monitor_pkg::CODE_W-1:0]       SECOND_FAULT_SLOT_O,
  output logic [fault_monitor_pkg::CODE_W-1:0]       THIRD_FAULT_SLOT_O,
  output logic [fault_monitor_pkg::CODE_W-1:0]       OLDEST_FAULT_SLOT_O,
  output logic [fault_monitor_pkg::BETWEEN_W-1:0]    HOURS_BETWEEN_FAULTS_O,
  output fault_monitor_pkg::drive_snap_t             FAULT_SNAPSHOT_O,
  // hour counters
  output logic [fault_monitor_pkg::HOURS_W-1:0]      POWER_ON_HOURS_O,
  output logic [fault_monitor_pkg::HOURS_W-1:0]      RUN_HOURS_O,
  output logic                                       HOUR_TICK_O,
  // live readings
  output logic [fault_monitor_pkg::TERM_W-1:0]       LIVE_INPUT_TERMINAL_STATUS_O,
  output logic [fault_monitor_pkg::TERM_W-1:0]       LIVE_OUTPUT_TERMINAL_STATUS_O,
  output logic [fault_monitor_pkg::VALUE_W-1:0]      ENCODER_SPEED_FEEDBACK_O,
  output logic [fault_monitor_pkg::VALUE_W-1:0]      MOTOR_SPEED_READING_O,
  output logic                                       MOTOR_SPEED_VALID_O,
  output fault_monitor_pkg::analog_in_t              ANALOG_READING_O,
  output logic [fault_monitor_pkg::VALUE_W-1:0]      CONTROLLER_TARGET_O,
  output logic [fault_monitor_pkg::VALUE_W-1:0]      FIRST_ANALOG_OUTPUT_O,
  output logic [fault_monitor_pkg::VALUE_W-1:0]      SECOND_ANALOG_OUTPUT_O
);
  import fault_monitor_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [63:0]                     tick_cnt;
    logic                            tick;
    fault_state_t                    fstate;
    logic [SLOT_COUNT*CODE_W-1:0]    slots;
    logic [BETWEEN_W-1:0]            between;
    logic [BETWEEN_W-1:0]            since;
    drive_snap_t                     snap;
    logic [HOURS_W-1:0]              pwr_hours;
    logic [HOURS_W-1:0]              run_hours;
    logic [TERM_W-1:0]               live_in;
    logic [TERM_W-1:0]               live_out;
    logic [VALUE_W-1:0]              enc_speed;
    logic [VALUE_W-1:0]              rpm;
    logic                            rpm_valid;
    analog_in_t                      analog;
    logic [VALUE_W-1:0]              target;
    logic [VALUE_W-1:0]              ao1;
    logic [VALUE_W-1:0]              ao2;
  } mon_state_t;

  mon_state_t st_r;
  mon_state_t st_nxt;

  localparam logic [63:0] TICK_LAST = 64'(HOUR_CYCLES_P - 1);

  // selector routing; other codes drive zero
  function automatic logic [VALUE_W-1:0] route(input logic [SEL_W-1:0] sel,
                                               input analog_in_t a);
    logic [VALUE_W-1:0] v;
    v = '0;
    case (sel)
      SEL_VOLTAGE_IN: v = a.voltage_in;  // R9
      SEL_CURRENT_IN: v = a.current_in;  // R9
      SEL_THIRD_IN:   v = a.third_in;    // R9
      default:        v = '0;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    // common hour timebase
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt == TICK_LAST) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick     = 1'b1;  // R14
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 64'h1;
    end
    // power-on and run hours wrap naturally at 16 bits
    if (st_r.tick) begin
      st_nxt.pwr_hours = st_r.pwr_hours + 16'h0001;  // R5 R14
      if (RUN_I) begin
        st_nxt.run_hours = st_r.run_hours + 16'h0001;  // R6
      end
      if (st_r.since != BETWEEN_MAX) begin
        st_nxt.since = st_r.since + 17'h00001;  // R2
      end
    end
    // fault event: shift history, sample drive, latch elapsed hours
    case (st_r.fstate)
      ST_CLEAR, ST_FAULTED: begin
        if (FAULT_PULSE_I) begin
          st_nxt.slots   = {st_r.slots[(SLOT_COUNT-1)*CODE_W-1:0],
                            FAULT_CODE_I};  // R1
          st_nxt.snap    = LIVE_I;          // R3 R8
          st_nxt.between = st_r.since;      // R2
          st_nxt.since   = BETWEEN_RESET;
          st_nxt.fstate  = ST_FAULTED;
        end else if (FAULT_RESET_I && st_r.fstate == ST_FAULTED) begin
          st_nxt.snap    = '0;              // R4
          st_nxt.between = BETWEEN_RESET;   // R2
          st_nxt.since   = BETWEEN_RESET;
          st_nxt.fstate  = ST_CLEAR;
        end
      end
      default: st_nxt.fstate = ST_CLEAR;
    endcase
    // live readings
    st_nxt.live_in   = LIVE_I.in_term;          // R7
    st_nxt.live_out  = LIVE_I.out_term;         // R8
    st_nxt.enc_speed = ENCODER_SPEED_I;         // R10
    st_nxt.rpm       = ENCODER_FEEDBACK_EN_I ? MOTOR_RPM_I : '0;  // R11
    st_nxt.rpm_valid = ENCODER_FEEDBACK_EN_I;   // R11
    st_nxt.analog    = ANALOG_IN_I;             // R12
    st_nxt.target    = CLOSED_LOOP_EN_I ? ANALOG_IN_I.third_in : '0;  // R13
    st_nxt.ao1       = route(FIRST_OUTPUT_SELECTOR_I, ANALOG_IN_I);
    st_nxt.ao2       = route(SECOND_OUTPUT_SELECTOR_I, ANALOG_IN_I);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      st_r           <= '0;
      st_r.fstate    <= ST_CLEAR;
      st_r.pwr_hours <= HOURS_RESET;
      st_r.run_hours <= HOURS_RESET;
      st_r.between   <= BETWEEN_RESET;
      st_r.since     <= BETWEEN_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign NEWEST_FAULT_SLOT_O           = st_r.slots[CODE_W-1:0];
  assign SECOND_FAULT_SLOT_O           = st_r.slots[2*CODE_W-1:CODE_W];
  assign THIRD_FAULT_SLOT_O            = st_r.slots[3*CODE_W-1:2*CODE_W];
  assign OLDEST_FAULT_SLOT_O           = st_r.slots[4*CODE_W-1:3*CODE_W];
  assign HOURS_BETWEEN_FAULTS_O        = st_r.between;
  assign FAULT_SNAPSHOT_O              = st_r.snap;
  assign POWER_ON_HOURS_O              = st_r.pwr_hours;
  assign RUN_HOURS_O                   = st_r.run_hours;
  assign HOUR_TICK_O                   = st_r.tick;
  assign LIVE_INPUT_TERMINAL_STATUS_O  = st_r.live_in;
  assign LIVE_OUTPUT_TERMINAL_STATUS_O = st_r.live_out;
  assign ENCODER_SPEED_FEEDBACK_O      = st_r.enc_speed;
  assign MOTOR_SPEED_READING_O         = st_r.rpm;
  assign MOTOR_SPEED_VALID_O           = st_r.rpm_valid;
  assign ANALOG_READING_O              = st_r.analog;
  assign CONTROLLER_TARGET_O           = st_r.target;
  assign FIRST_ANALOG_OUTPUT_O         = st_r.ao1;
  assign SECOND_ANALOG_OUTPUT_O        = st_r.ao2;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_slot_shift: assert property (  // R1
    @(posedge MCLK_I) disable iff (RESET_I)
    FAULT_PULSE_I |=> NEWEST_FAULT_SLOT_O == $past(FAULT_CODE_I) &&
      SECOND_FAULT_SLOT_O == $past(NEWEST_FAULT_SLOT_O) &&
      THIRD_FAULT_SLOT_O == $past(SECOND_FAULT_SLOT_O) &&
      OLDEST_FAULT_SLOT_O == $past(THIRD_FAULT_SLOT_O)
  ) else $error("fault history did not shift");

  a_slot_keep: assert property (  // R1
    @(posedge MCLK_I) disable iff (RESET_I)
    !FAULT_PULSE_I |=> $stable(NEWEST_FAULT_SLOT_O) &&
      $stable(OLDEST_FAULT_SLOT_O)
  ) else $error("fault history moved without a fault");

  a_between_latch: assert property (  // R2
    @(posedge MCLK_I) disable iff (RESET_I)
    FAULT_PULSE_I |=> HOURS_BETWEEN_FAULTS_O == $past(st_r.since)
  ) else $error("hours between faults not latched");

  a_snap_capture: assert property (  // R3
    @(posedge MCLK_I) disable iff (RESET_I)
    FAULT_PULSE_I |=> FAULT_SNAPSHOT_O == $past(LIVE_I)
  ) else $error("snapshot not captured");

  a_snap_encoding: assert property (  // R8
    @(posedge MCLK_I) disable iff (RESET_I)
    FAULT_PULSE_I |=>
      FAULT_SNAPSHOT_O.in_term == LIVE_INPUT_TERMINAL_STATUS_O &&
      FAULT_SNAPSHOT_O.out_term == LIVE_OUTPUT_TERMINAL_STATUS_O
  ) else $error("snapshot terminal encoding differs from live");

  a_snap_clear: assert property (  // R4
    @(posedge MCLK_I) disable iff (RESET_I)
    (FAULT_RESET_I && !FAULT_PULSE_I && st_r.fstate == ST_FAULTED)
    |=> FAULT_SNAPSHOT_O == '0 && HOURS_BETWEEN_FAULTS_O == '0
  ) else $error("snapshot not cleared");

  a_power_wrap: assert property (  // R5
    @(posedge MCLK_I) disable iff (RESET_I)
    HOUR_TICK_O |=>
      POWER_ON_HOURS_O == $past(POWER_ON_HOURS_O) + 16'h0001
  ) else $error("power-on hours did not advance");

  a_hours_hold: assert property (  // R14
    @(posedge MCLK_I) disable iff (RESET_I)
    !HOUR_TICK_O |=> $stable(POWER_ON_HOURS_O) && $stable(RUN_HOURS_O)
  ) else $error("hour counters moved without a tick");

  a_run_advance: assert property (  // R6
    @(posedge MCLK_I) disable iff (RESET_I)
    (HOUR_TICK_O && RUN_I) |=>
      RUN_HOURS_O == $past(RUN_HOURS_O) + 16'h0001
  ) else $error("run hours did not advance");

  a_run_hold: assert property (  // R6
    @(posedge MCLK_I) disable iff (RESET_I)
    (HOUR_TICK_O && !RUN_I) |=> $stable(RUN_HOURS_O)
  ) else $error("run hours moved while stopped");

  a_tick_single: assert property (  // R14
    @(posedge MCLK_I) disable iff (RESET_I)
    HOUR_TICK_O |=> !HOUR_TICK_O
  ) else $error("hour tick longer than one cycle");

  a_live_input: assert property (  // R7
    @(posedge MCLK_I) disable iff (RESET_I)
    ##1 LIVE_INPUT_TERMINAL_STATUS_O == $past(LIVE_I.in_term)
  ) else $error("live input status stale");

  a_enc_feedback: assert property (  // R10
    @(posedge MCLK_I) disable iff (RESET_I)
    ##1 ENCODER_SPEED_FEEDBACK_O == $past(ENCODER_SPEED_I)
  ) else $error("encoder speed feedback stale");

  a_analog_live: assert property (  // R12
    @(posedge MCLK_I) disable iff (RESET_I)
    ##1 ANALOG_READING_O == $past(ANALOG_IN_I)
  ) else $error("analog readings stale");

  a_select_route: assert property (  // R9
    @(posedge MCLK_I) disable iff (RESET_I)
    FIRST_OUTPUT_SELECTOR_I == SEL_THIRD_IN
    |=> FIRST_ANALOG_OUTPUT_O == $past(ANALOG_IN_I.third_in)
  ) else $error("selector routing wrong");

  a_second_route: assert property (  // R9
    @(posedge MCLK_I) disable iff (RESET_I)
    SECOND_OUTPUT_SELECTOR_I == SEL_VOLTAGE_IN
    |=> SECOND_ANALOG_OUTPUT_O == $past(ANALOG_IN_I.voltage_in)
  ) else $error("second selector routing wrong");

  a_rpm_gate: assert property (  // R11
    @(posedge MCLK_I) disable iff (RESET_I)
    !ENCODER_FEEDBACK_EN_I |=> MOTOR_SPEED_READING_O == '0 &&
      !MOTOR_SPEED_VALID_O
  ) else $error("motor speed shown without feedback");

  a_rpm_pass: assert property (  // R11
    @(posedge MCLK_I) disable iff (RESET_I)
    ENCODER_FEEDBACK_EN_I |=>
      MOTOR_SPEED_READING_O == $past(MOTOR_RPM_I) && MOTOR_SPEED_VALID_O
  ) else $error("motor speed not shown with feedback");

  a_target_gate: assert property (  // R13
    @(posedge MCLK_I) disable iff (RESET_I)
    CLOSED_LOOP_EN_I |=>
      CONTROLLER_TARGET_O == $past(ANALOG_IN_I.third_in)
  ) else $error("controller target wrong");

  c_fault_seen: cover property (@(posedge MCLK_I) disable iff (RESET_I)
    FAULT_PULSE_I ##1 FAULT_PULSE_I);
  c_fault_reset: cover property (@(posedge MCLK_I) disable iff (RESET_I)
    st_r.fstate == ST_FAULTED ##1 st_r.fstate == ST_CLEAR);
  c_hour_tick: cover property (@(posedge MCLK_I) disable iff (RESET_I)
    HOUR_TICK_O && RUN_I);
  c_clear_refused: cover property (@(posedge MCLK_I) disable iff (RESET_I)
    FAULT_RESET_I && st_r.fstate == ST_CLEAR);
  c_fault_beats_clear: cover property (@(posedge MCLK_I) disable iff (RESET_I)
    FAULT_PULSE_I && FAULT_RESET_I);

endmodule

// >>> fault_monitor_pkg.sv
package fault_monitor_pkg;

  // clock and hour timebase
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned HOUR_SECONDS    = 3600;
  localparam longint      HOUR_CYCLES     = 64'(CLK_HZ) * 64'(HOUR_SECONDS);

  // widths
  localparam int unsigned CODE_W          = 8;
  localparam int unsigned SLOT_COUNT      = 4;
  localparam int unsigned HOURS_W         = 16;
  localparam int unsigned BETWEEN_W       = 17;  // range reaches 65536
  localparam int unsigned VALUE_W         = 16;
  localparam int unsigned TERM_W          = 8;
  localparam int unsigned SEL_W           = 8;

  // reset values
  localparam logic [HOURS_W-1:0]   HOURS_RESET   = 16'h0000;
  localparam logic [BETWEEN_W-1:0] BETWEEN_RESET = 17'h00000;
  localparam logic [BETWEEN_W-1:0] BETWEEN_MAX   = 17'h10000;
  localparam logic [CODE_W-1:0]    NO_FAULT_CODE = 8'h00;

  // analog output selector codes
  localparam logic [SEL_W-1:0] SEL_VOLTAGE_IN = 8'h05;
  localparam logic [SEL_W-1:0] SEL_CURRENT_IN = 8'h06;
  localparam logic [SEL_W-1:0] SEL_THIRD_IN   = 8'h07;

  // drive quantities sampled at a fault
  typedef struct packed {
    logic [VALUE_W-1:0] freq_cmd;      // 0.01 Hz
    logic [VALUE_W-1:0] out_freq;      // 0.01 Hz
    logic [VALUE_W-1:0] out_current;   // 0.1 A
    logic [VALUE_W-1:0] out_voltage;   // 0.1 V
    logic [VALUE_W-1:0] dc_voltage;    // 0.1 V
    logic [TERM_W-1:0]  in_term;       // 1 = closed
    logic [TERM_W-1:0]  out_term;
  } drive_snap_t;

  // analog input readings, 0.1 percent steps
  typedef struct packed {
    logic [VALUE_W-1:0] voltage_in;
    logic [VALUE_W-1:0] current_in;
    logic [VALUE_W-1:0] third_in;
  } analog_in_t;

  typedef enum logic [1:0] {
    ST_CLEAR   = 2'b00,
    ST_FAULTED = 2'b01
  } fault_state_t;

endpackage

// >>> panel_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// operator panel: counts the hour ticks it sees, to judge shown hours
module panel_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // monitor side
  input  wire logic        tick_i,
  output logic [15:0]      ticks_seen_o
);
  // one count per one-cycle tick pulse
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ticks_seen_o <= 16'h0000;
    end else if (tick_i) begin
      ticks_seen_o <= ticks_seen_o + 16'h0001;
    end
  end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import fault_monitor_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic mclk = 1'b0, reset = 1'b1, pulse = 1'b0, f_reset = 1'b0, run = 1'b0;
  logic enc_en = 1'b0, loop_en = 1'b0, tick, spd_ok;
  logic [CODE_W-1:0] code = 8'h00, s0, s1, s2, s3;
  drive_snap_t live = '0, snap, live2;
  analog_in_t current_analog_input = '0, rd;
  logic [VALUE_W-1:0] enc = 16'h0000, rpm = 16'h0000, enc_fb, spd, tgt;
  logic [VALUE_W-1:0] ao1, ao2;
  logic [SEL_W-1:0] sel1 = 8'h00, sel2 = 8'h00;
  logic [BETWEEN_W-1:0] btw;
  logic [HOURS_W-1:0] pwr, runh, seen;
  logic [TERM_W-1:0] in_st, out_st;
  logic [7:0] codes [4] = '{8'h05, 8'h06, 8'h07, 8'h00};
  int fails = 0, compares = 0, cycles = 0;
  always #10 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  // design with a short hour, and the panel watching it
  fault_history_and_hour_monitor #(.HOUR_CYCLES_P(16))
    fault_history_and_hour_monitor_i (
    .MCLK_I(mclk), .RESET_I(reset), .FAULT_PULSE_I(pulse),
    .FAULT_CODE_I(code), .FAULT_RESET_I(f_reset), .RUN_I(run),
    .LIVE_I(live), .ANALOG_IN_I(current_analog_input), .ENCODER_SPEED_I(enc),
    .MOTOR_RPM_I(rpm), .ENCODER_FEEDBACK_EN_I(enc_en),
    .CLOSED_LOOP_EN_I(loop_en), .FIRST_OUTPUT_SELECTOR_I(sel1),
    .SECOND_OUTPUT_SELECTOR_I(sel2), .NEWEST_FAULT_SLOT_O(s0),
    .SECOND_FAULT_SLOT_O(s1), .THIRD_FAULT_SLOT_O(s2),
    .OLDEST_FAULT_SLOT_O(s3), .HOURS_BETWEEN_FAULTS_O(btw),
    .FAULT_SNAPSHOT_O(snap), .POWER_ON_HOURS_O(pwr), .RUN_HOURS_O(runh),
    .HOUR_TICK_O(tick), .LIVE_INPUT_TERMINAL_STATUS_O(in_st),
    .LIVE_OUTPUT_TERMINAL_STATUS_O(out_st),
    .ENCODER_SPEED_FEEDBACK_O(enc_fb), .MOTOR_SPEED_READING_O(spd),
    .MOTOR_SPEED_VALID_O(spd_ok), .ANALOG_READING_O(rd),
    .CONTROLLER_TARGET_O(tgt), .FIRST_ANALOG_OUTPUT_O(ao1),
    .SECOND_ANALOG_OUTPUT_O(ao2));
  panel_model panel_model_i (.clk_i(mclk), .reset_i(reset), .tick_i(tick),
    .ticks_seen_o(seen));
  ////////////////////////////////////////////////////////////////////////////
  // helpers: waits, compares, fault events, verdict
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t value got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_snap(input drive_snap_t got, input drive_snap_t exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t snapshot got %h expected %h", $time, got, exp);
    end
  endtask
  // pulse stays up so back to back faults never toggle it in one step
  task fire(input logic [7:0] c);
    code = c;
    pulse = 1'b1;
    step(1);
  endtask
  task wait_tick;
    for (int n = 0; n < 40 && tick !== 1'b1; n++) step(1);
    chk(32'(tick), 32'h1);
    step(1);
  endtask
  function automatic logic [15:0] pick(input logic [7:0] c);
    return c == 8'h05 ? current_analog_input.voltage_in : c == 8'h06 ? current_analog_input.current_in :
           c == 8'h07 ? current_analog_input.third_in : 16'h0000;
  endfunction
  task final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    step(10);
    reset = 1'b0;
    chk(32'(pwr), 32'h0);
    live = '{16'h1234, 16'h2345, 16'h0456, 16'h0567, 16'h0678, 8'hA5, 8'h3C};
    live2 = ~live;
    current_analog_input = '{16'h03E8, 16'h01F4, 16'h0064};
    enc = 16'h03E8;
    rpm = 16'h0708;
    run = 1'b1;
    step(2);
    chk(32'(in_st), 32'hA5);
    chk(32'(out_st), 32'h3C);
    chk(32'(enc_fb), 32'h03E8);
    chk(32'(spd), 32'h0);
    chk(32'(spd_ok), 32'h0);
    chk(32'(tgt), 32'h0);
    chk(32'(rd.voltage_in), 32'h03E8);
    chk(32'(rd.current_in), 32'h01F4);
    chk(32'(rd.third_in), 32'h0064);
    enc_en = 1'b1;
    loop_en = 1'b1;
    step(2);
    chk(32'(spd), 32'h0708);
    chk(32'(spd_ok), 32'h1);
    chk(32'(tgt), 32'h0064);
    for (int i = 0; i < 4; i++) begin
      sel1 = codes[i];
      sel2 = codes[(i + 1) % 4];
      step(2);
      chk(32'(ao1), 32'(pick(codes[i])));
      chk(32'(ao2), 32'(pick(codes[(i + 1) % 4])));
    end
    for (int k = 1; k <= 3; k++) begin
      wait_tick;
      chk(32'(pwr), 32'(k));
      chk(32'(runh), 32'(k));
      chk(32'(pwr), 32'(seen));
    end
    run = 1'b0;
    wait_tick;
    chk(32'(runh), 32'h3);
    chk(32'(pwr), 32'h4);
    run = 1'b1;
    fire(8'h11);
    chk(32'(s0), 32'h11);
    chk(32'(btw), 32'h4);
    chk_snap(snap, live);
    fire(8'h22);
    fire(8'h33);
    fire(8'h44);
    live = live2;
    fire(8'h55);
    pulse = 1'b0;
    chk({s0, s1, s2, s3}, 32'h55443322);
    chk(32'(btw), 32'h0);
    chk_snap(snap, live2);
    f_reset = 1'b1;
    step(1);
    f_reset = 1'b0;
    chk_snap(snap, '0);
    chk(32'(btw), 32'h0);
    chk(32'(s0), 32'h55);
    wait_tick;
    // a clear with no fault pending is refused: elapsed hours stay
    f_reset = 1'b1;
    step(1);
    f_reset = 1'b0;
    fire(8'h66);
    chk(32'(btw), 32'h1);
    chk({s0, s1, s2, s3}, 32'h66554433);
    // a fault in the same cycle as a clear wins
    f_reset = 1'b1;
    fire(8'h77);
    pulse = 1'b0;
    f_reset = 1'b0;
    chk_snap(snap, live2);
    chk({s0, s1, s2, s3}, 32'h77665544);
    chk(32'(btw), 32'h0);
    final_report;
  end
endmodule
